// ### rtl/ascc_map.vh
`ifndef ASCC_MAP_VH
`define ASCC_MAP_VH
// ==========================================
// Register offsets
`define ASCC_OFS_DEV_INDEX   12'h008
`define ASCC_OFS_REF_SEL     12'h024
`define ASCC_OFS_DIODE       12'h028
`define ASCC_OFS_PWR_MODE    12'h03F
`define ASCC_OFS_PIN_FUNC    12'h040
`define ASCC_OFS_DIV_RATIO   12'h10B
`define ASCC_OFS_HALF_DLY    12'h10C
`define ASCC_OFS_SYNC_CTRL   12'h10D
`define ASCC_OFS_FINE_EN     12'h117
`define ASCC_OFS_FINE_VAL    12'h118
// ==========================================
// Field positions
`define ASCC_DIV_SEL_MSB     1
`define ASCC_DIV_SEL_LSB     0
`define ASCC_SYNC_EN_BIT     7
`define ASCC_SYNC_STATE_MSB  2
`define ASCC_SYNC_STATE_LSB  0
`define ASCC_FINE_EN_BIT     0
`define ASCC_REF_EXT_BIT     0
`define ASCC_DIODE_EN_BIT    0
`define ASCC_FD_SEL_MSB      2
`define ASCC_FD_SEL_LSB      0
`define ASCC_FD_SEL_TEMP     3'h1
`define ASCC_PIN_STBY_BIT    6
`define ASCC_PWR_MODE_MSB    1
`define ASCC_PWR_MODE_LSB    0
`define ASCC_PWR_MODE_STBY   2'h2
`define ASCC_PWR_MODE_PDWN   2'h3
// ==========================================
// Reset values
`define ASCC_RST_DEV_INDEX   8'h03
`define ASCC_RST_DEFAULT     8'h00
// ==========================================
// Timing and fine delay scale
`define ASCC_CLK_MHZ         40
`define ASCC_DP_RST_NS       100
`define ASCC_FINE_STEP_FS    1700
`define ASCC_FINE_NEG_STEPS  8'h59
`define ASCC_FINE_MAX_CODE   8'hB1
`endif

// ### rtl/ascc_top.v
// Summary of operation
// - Input clock divided by 1, 2, 4 or 8 from the divider ratio register.
// - Divided sample clock limited to 500 MHz; divider rated to 4 GHz input.
// - With sync enable bit 7 set, a valid sync loads a programmed divider state.
// - Per-channel phase delay of divider output by one input clock cycle, enabled per channel.
// - Fine delay enable bit 0 and 8-bit value, separately per channel.
// - Fine delay spans -151.7 ps to +150 ps in about 1.7 ps steps.
// - Fine delay setting acts at the next sample strobe after a write, no update command.
// - Writing the fine delay enable on resets the digital datapath.
// - Reference select chooses internal or external 1.0 V reference.
// - Sleep pin high enters low power; default is full power-down.
// - Power-down also selectable through the power mode register.
// - Temperature diode enable is bit 0 of the diode control register.
// - Pin function bits 2:0 route diode voltage to the channel A fast-detect pin.
// - Converter clock has 50% duty at ratios 2, 4 and 8 whatever the input duty; ratio 1 holds it high.
`timescale 1ns/100ps
`include "ascc_map.vh"
module ascc_top (
    // Clock and reset
    input  wire        core_clk_in,
    input  wire        reset_n_in,
    // Serial port
    input  wire        spi_sclk_in,
    input  wire        spi_cs_n_in,
    input  wire        spi_sdi_in,
    output wire        spi_sdo_out,
    output wire        spi_sdo_oe_n_out,
    // Sync and sleep pins
    input  wire        sync_in,
    input  wire        sleep_control_pin_in,
    // Sample clock, bit 0 is channel A
    output wire [1:0]  sample_strobe_out,
    output wire [1:0]  sample_clk_out,
    output wire [7:0]  fine_delay_step_a_out,
    output wire [7:0]  fine_delay_step_b_out,
    output wire        datapath_reset_out,
    // Analog control
    output wire        ref_external_out,
    output wire        power_down_out,
    output wire        standby_out,
    output wire        temp_diode_en_out,
    output wire        fast_detect_out_a_temp_out
);

// ==========================================
// Constants
localparam integer DP_RST_FULL = (`ASCC_DP_RST_NS * `ASCC_CLK_MHZ + 999) / 1000;
localparam [7:0]   DP_RST_CYC  = DP_RST_FULL[7:0];

// ==========================================
// Functions
function [2:0] div_last;
    input [1:0] sel;
    begin
        div_last = 3'h7 >> (2'h3 - sel);
    end
endfunction

function clk_level;
    input [2:0] cnt;
    input [1:0] sel;
    begin
        case (sel)
            2'h1:    clk_level = ~cnt[0];
            2'h2:    clk_level = ~cnt[1];
            2'h3:    clk_level = ~cnt[2];
            default: clk_level = 1'b1;
        endcase
    end
endfunction

function [7:0] fine_map;
    input [7:0] code;
    reg   [7:0] clip;
    begin
        clip = (code > `ASCC_FINE_MAX_CODE) ? `ASCC_FINE_MAX_CODE : code;
        fine_map = clip - `ASCC_FINE_NEG_STEPS;
    end
endfunction

// ==========================================
// Pin synchronisers
reg        sclk_s1;
reg        sclk_s2;
reg        sclk_s3;
reg        cs_s1;
reg        cs_s2;
reg        sdi_s1;
reg        sdi_s2;
reg        sync_s1;
reg        sync_s2;
reg        sync_s3;
reg        slp_s1;
reg        slp_s2;

always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        sclk_s1 <= 1'b0;
        sclk_s2 <= 1'b0;
        sclk_s3 <= 1'b0;
        cs_s1   <= 1'b1;
        cs_s2   <= 1'b1;
        sdi_s1  <= 1'b0;
        sdi_s2  <= 1'b0;
        sync_s1 <= 1'b0;
        sync_s2 <= 1'b0;
        sync_s3 <= 1'b0;
        slp_s1  <= 1'b0;
        slp_s2  <= 1'b0;
    end else begin
        sclk_s1 <= spi_sclk_in;
        sclk_s2 <= sclk_s1;
        sclk_s3 <= sclk_s2;
        cs_s1   <= spi_cs_n_in;
        cs_s2   <= cs_s1;
        sdi_s1  <= spi_sdi_in;
        sdi_s2  <= sdi_s1;
        sync_s1 <= sync_in;
        sync_s2 <= sync_s1;
        sync_s3 <= sync_s2;
        slp_s1  <= sleep_control_pin_in;
        slp_s2  <= slp_s1;
    end
end

// ==========================================
// Register storage
reg  [7:0]  dev_index_reg;
reg  [7:0]  ref_sel_reg;
reg  [7:0]  power_mode_reg;
reg  [7:0]  pin_func_reg;
reg  [7:0]  div_ratio_reg;
reg  [7:0]  half_dly_reg;
reg  [7:0]  sync_ctrl_reg;
reg  [15:0] diode_ctrl_reg;
reg  [15:0] fine_en_reg;
reg  [15:0] fine_val_reg;

// ==========================================
// Serial port: 16-bit instruction (read bit, address) then one data byte
reg  [4:0]  bit_cnt_reg;
reg  [15:0] shift_reg;
reg  [11:0] addr_reg;
reg         addr_ok_reg;
reg         rd_reg;
reg  [7:0]  rd_shift_reg;
reg         sdo_reg;
reg         sdo_oe_n_reg;
reg  [7:0]  rd_data;

wire        cs_act     = ~cs_s2;
wire        sclk_rise  = sclk_s2 & ~sclk_s3;
wire        sclk_fall  = ~sclk_s2 & sclk_s3;
wire [15:0] shift_next = {shift_reg[14:0], sdi_s2};
wire        wr_hit     = cs_act & sclk_rise & (bit_cnt_reg == 5'h17)
                         & ~rd_reg & addr_ok_reg;
wire [7:0]  wr_data    = shift_next[7:0];
// Local registers read back from the lowest selected channel
wire        rd_ch      = ~dev_index_reg[0];

always @* begin
    case (shift_next[11:0])
        `ASCC_OFS_DEV_INDEX: rd_data = dev_index_reg;
        `ASCC_OFS_REF_SEL:   rd_data = ref_sel_reg;
        `ASCC_OFS_DIODE:     rd_data = diode_ctrl_reg[{rd_ch, 3'h0} +: 8];
        `ASCC_OFS_PWR_MODE:  rd_data = power_mode_reg;
        `ASCC_OFS_PIN_FUNC:  rd_data = pin_func_reg;
        `ASCC_OFS_DIV_RATIO: rd_data = div_ratio_reg;
        `ASCC_OFS_HALF_DLY:  rd_data = half_dly_reg;
        `ASCC_OFS_SYNC_CTRL: rd_data = sync_ctrl_reg;
        `ASCC_OFS_FINE_EN:   rd_data = fine_en_reg[{rd_ch, 3'h0} +: 8];
        `ASCC_OFS_FINE_VAL:  rd_data = fine_val_reg[{rd_ch, 3'h0} +: 8];
        default:             rd_data = 8'h00;
    endcase
end

always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        bit_cnt_reg  <= 5'h00;
        shift_reg    <= 16'h0000;
        addr_reg     <= 12'h000;
        addr_ok_reg  <= 1'b0;
        rd_reg       <= 1'b0;
        rd_shift_reg <= 8'h00;
        sdo_reg      <= 1'b0;
        sdo_oe_n_reg <= 1'b1;
    end else if (!cs_act) begin
        bit_cnt_reg  <= 5'h00;
        rd_reg       <= 1'b0;
        sdo_oe_n_reg <= 1'b1;
    end else if (sclk_rise) begin
        shift_reg <= shift_next;
        if (bit_cnt_reg < 5'h18) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
        if (bit_cnt_reg == 5'h0F) begin
            rd_reg       <= shift_next[15];
            addr_reg     <= shift_next[11:0];
            addr_ok_reg  <= (shift_next[14:12] == 3'h0);
            rd_shift_reg <= (shift_next[14:12] == 3'h0) ? rd_data : 8'h00;
        end
    end else if (sclk_fall) begin
        if (rd_reg && bit_cnt_reg >= 5'h10 && bit_cnt_reg < 5'h18) begin
            sdo_reg      <= rd_shift_reg[7];
            rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
            sdo_oe_n_reg <= 1'b0;
        end else begin
            sdo_oe_n_reg <= 1'b1;
        end
    end
end

// ==========================================
// Global register writes
always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        dev_index_reg  <= `ASCC_RST_DEV_INDEX;
        ref_sel_reg    <= `ASCC_RST_DEFAULT;
        power_mode_reg <= `ASCC_RST_DEFAULT;
        pin_func_reg   <= `ASCC_RST_DEFAULT;
        div_ratio_reg  <= `ASCC_RST_DEFAULT;
        half_dly_reg   <= `ASCC_RST_DEFAULT;
        sync_ctrl_reg  <= `ASCC_RST_DEFAULT;
    end else if (wr_hit) begin
        case (addr_reg)
            `ASCC_OFS_DEV_INDEX: dev_index_reg  <= wr_data;
            `ASCC_OFS_REF_SEL:   ref_sel_reg    <= wr_data;
            `ASCC_OFS_PWR_MODE:  power_mode_reg <= wr_data;
            `ASCC_OFS_PIN_FUNC:  pin_func_reg   <= wr_data;
            `ASCC_OFS_DIV_RATIO: div_ratio_reg  <= wr_data;
            `ASCC_OFS_HALF_DLY:  half_dly_reg   <= wr_data;
            `ASCC_OFS_SYNC_CTRL: sync_ctrl_reg  <= wr_data;
            default:             dev_index_reg  <= dev_index_reg;
        endcase
    end
end

// ==========================================
// Per-channel local registers, written to every selected channel
genvar ch;
generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_local
        wire sel_wr = wr_hit & dev_index_reg[ch];
        always @(posedge core_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                diode_ctrl_reg[ch*8 +: 8] <= `ASCC_RST_DEFAULT;
                fine_en_reg[ch*8 +: 8]    <= `ASCC_RST_DEFAULT;
                fine_val_reg[ch*8 +: 8]   <= `ASCC_RST_DEFAULT;
            end else if (sel_wr) begin
                if (addr_reg == `ASCC_OFS_DIODE) begin
                    diode_ctrl_reg[ch*8 +: 8] <= wr_data;
                end
                if (addr_reg == `ASCC_OFS_FINE_EN) begin
                    fine_en_reg[ch*8 +: 8] <= wr_data;
                end
                if (addr_reg == `ASCC_OFS_FINE_VAL) begin
                    fine_val_reg[ch*8 +: 8] <= wr_data;
                end
            end
        end
    end
endgenerate

// ==========================================
// Datapath reset on fine delay enable
reg  [7:0] dp_cnt_reg;
reg        dp_rst_reg;
wire       fine_on_wr = wr_hit & (addr_reg == `ASCC_OFS_FINE_EN)
                        & wr_data[`ASCC_FINE_EN_BIT] & (dev_index_reg[1:0] != 2'h0);

always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        dp_cnt_reg <= 8'h00;
        dp_rst_reg <= 1'b0;
    end else if (fine_on_wr) begin
        dp_cnt_reg <= DP_RST_CYC;
        dp_rst_reg <= 1'b1;
    end else begin
        if (dp_cnt_reg != 8'h00) begin
            dp_cnt_reg <= dp_cnt_reg - 8'h01;
        end
        dp_rst_reg <= (dp_cnt_reg > 8'h01);
    end
end

// ==========================================
// Clock divider with sync alignment
// Ratio comes straight from the register, so the host must set it before
// a faster clock arrives; rate limits are the board's duty.
reg  [2:0] div_cnt_reg;
reg        base_strobe_reg;
reg        base_level_reg;
wire [1:0] div_sel   = div_ratio_reg[`ASCC_DIV_SEL_MSB:`ASCC_DIV_SEL_LSB];
wire [2:0] div_top   = div_last(div_sel);
wire       sync_edge = sync_s2 & ~sync_s3 & sync_ctrl_reg[`ASCC_SYNC_EN_BIT];

always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        div_cnt_reg     <= 3'h0;
        base_strobe_reg <= 1'b0;
        base_level_reg  <= 1'b0;
    end else begin
        if (sync_edge) begin
            div_cnt_reg <= sync_ctrl_reg[`ASCC_SYNC_STATE_MSB:`ASCC_SYNC_STATE_LSB]
                           & div_top;
        end else if (div_cnt_reg >= div_top) begin
            div_cnt_reg <= 3'h0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 3'h1;
        end
        base_strobe_reg <= (div_cnt_reg == 3'h0);
        // High for the first half of each period at ratios 2, 4 and 8, hence even duty; ratio 1 stays high
        base_level_reg  <= clk_level(div_cnt_reg, div_sel);
    end
end

// ==========================================
// Per-channel phase delay and fine delay
reg  [1:0]  strobe_reg;
reg  [1:0]  level_reg;
reg  [1:0]  strobe_d_reg;
reg  [1:0]  level_d_reg;
reg  [15:0] fine_step_reg;

generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
        always @(posedge core_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                strobe_d_reg[ch]         <= 1'b0;
                level_d_reg[ch]          <= 1'b0;
                strobe_reg[ch]           <= 1'b0;
                level_reg[ch]            <= 1'b0;
                fine_step_reg[ch*8 +: 8] <= 8'h00;
            end else begin
                strobe_d_reg[ch] <= base_strobe_reg;
                level_d_reg[ch]  <= base_level_reg;
                if (half_dly_reg[ch]) begin
                    strobe_reg[ch] <= strobe_d_reg[ch];
                    level_reg[ch]  <= level_d_reg[ch];
                end else begin
                    strobe_reg[ch] <= base_strobe_reg;
                    level_reg[ch]  <= base_level_reg;
                end
                // Update only at a sample edge so no sample sees a torn code
                if (strobe_reg[ch]) begin
                    fine_step_reg[ch*8 +: 8] <=
                        fine_en_reg[ch*8 + `ASCC_FINE_EN_BIT]
                        ? fine_map(fine_val_reg[ch*8 +: 8])
                        : 8'h00;
                end
            end
        end
    end
endgenerate

// ==========================================
// Reference, power and temperature diode
reg        ref_ext_reg;
reg        pd_reg;
reg        stby_reg;
reg        diode_en_reg;
reg        fd_temp_reg;
wire [1:0] pwr_mode  = power_mode_reg[`ASCC_PWR_MODE_MSB:`ASCC_PWR_MODE_LSB];
wire       pin_stby  = pin_func_reg[`ASCC_PIN_STBY_BIT];
wire       pd_next   = (pwr_mode == `ASCC_PWR_MODE_PDWN) | (slp_s2 & ~pin_stby);
wire       stby_next = ~pd_next & ((pwr_mode == `ASCC_PWR_MODE_STBY)
                                   | (slp_s2 & pin_stby));

always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        ref_ext_reg  <= 1'b0;
        pd_reg       <= 1'b0;
        stby_reg     <= 1'b0;
        diode_en_reg <= 1'b0;
        fd_temp_reg  <= 1'b0;
    end else begin
        ref_ext_reg  <= ref_sel_reg[`ASCC_REF_EXT_BIT];
        pd_reg       <= pd_next;
        stby_reg     <= stby_next;
        diode_en_reg <= diode_ctrl_reg[`ASCC_DIODE_EN_BIT];
        fd_temp_reg  <= diode_ctrl_reg[`ASCC_DIODE_EN_BIT]
                        & (pin_func_reg[`ASCC_FD_SEL_MSB:`ASCC_FD_SEL_LSB]
                           == `ASCC_FD_SEL_TEMP);
    end
end

// ==========================================
// Outputs
assign spi_sdo_out                = sdo_reg;
assign spi_sdo_oe_n_out           = sdo_oe_n_reg;
assign sample_strobe_out          = strobe_reg;
assign sample_clk_out             = level_reg;
assign fine_delay_step_a_out      = fine_step_reg[7:0];
assign fine_delay_step_b_out      = fine_step_reg[15:8];
assign datapath_reset_out         = dp_rst_reg;
assign ref_external_out           = ref_ext_reg;
assign power_down_out             = pd_reg;
assign standby_out                = stby_reg;
assign temp_diode_en_out          = diode_en_reg;
assign fast_detect_out_a_temp_out = fd_temp_reg;

endmodule // ascc_top

// ### testbench/ascc_chk_sva.sv
`timescale 1ns/100ps
module ascc_chk (
    // Clock and reset
    input wire       core_clk_in,
    input wire       reset_n_in,
    // Pins
    input wire       spi_cs_n_in,
    input wire       sleep_control_pin_in,
    // Outputs
    input wire [1:0] sample_strobe_out,
    input wire [1:0] sample_clk_out,
    input wire [7:0] fine_delay_step_a_out,
    input wire [7:0] fine_delay_step_b_out,
    input wire       datapath_reset_out,
    input wire       power_down_out,
    input wire       standby_out,
    input wire       spi_sdo_oe_n_out
);
    // ==========
    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    a_dp_reset_len: assert property (
        $rose(datapath_reset_out) |-> datapath_reset_out [*4] ##1 !datapath_reset_out)
        else $error("Datapath reset pulse is not four cycles");
    a_fine_range: assert property (
        $signed(fine_delay_step_a_out) >= -89 && $signed(fine_delay_step_a_out) <= 88
        && $signed(fine_delay_step_b_out) >= -89 && $signed(fine_delay_step_b_out) <= 88)
        else $error("Fine delay step out of range");
    a_fine_timing: assert property (
        $changed(fine_delay_step_a_out) |-> (##[0:2] sample_strobe_out[0])
        or ($past(sample_strobe_out[0]) || $past(sample_strobe_out[0], 2)))
        else $error("Fine delay changed away from a strobe");
    a_strobe_ab: assert property (
        sample_strobe_out[0] |-> (##[0:1] sample_strobe_out[1]) or $past(sample_strobe_out[1]))
        else $error("Channel strobes more than one cycle apart");
    a_clk_strobe: assert property (
        (sample_strobe_out & ~sample_clk_out) == 2'h0)
        else $error("Strobe outside high half of sample clock");
    a_sleep_enter: assert property (
        $rose(sleep_control_pin_in) |-> ##[1:5] (power_down_out || standby_out))
        else $error("Sleep pin did not lower power");
    a_sdo_release: assert property (
        spi_cs_n_in [*6] |-> spi_sdo_oe_n_out)
        else $error("Read data driven while deselected");
    a_reset_quiet: assert property (
        !$past(reset_n_in) |-> !datapath_reset_out && spi_sdo_oe_n_out
        && !power_down_out && sample_strobe_out == 2'h0)
        else $error("Outputs active on first edge after reset");
endmodule // ascc_chk

bind ascc_top ascc_chk chk (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .spi_cs_n_in(spi_cs_n_in), .sleep_control_pin_in(sleep_control_pin_in),
    .sample_strobe_out(sample_strobe_out), .sample_clk_out(sample_clk_out),
    .fine_delay_step_a_out(fine_delay_step_a_out),
    .fine_delay_step_b_out(fine_delay_step_b_out),
    .datapath_reset_out(datapath_reset_out), .power_down_out(power_down_out),
    .standby_out(standby_out), .spi_sdo_oe_n_out(spi_sdo_oe_n_out));

// ### testbench/ascc_host.sv
`timescale 1ns/100ps
module ascc_host (
    // Clock
    input  wire clk_in,
    // Serial port
    input  wire spi_sdo_in,
    output reg  spi_sclk_out,
    output reg  spi_cs_n_out,
    output reg  spi_sdi_out
);
    // ==========
    // Frame: 24 bits MSB first; 5-clock phases keep the 4-clock minimum
    initial begin
        spi_sclk_out = 1'b0;
        spi_cs_n_out = 1'b1;
        spi_sdi_out  = 1'b0;
    end
    task xfer(input rd, input [14:0] addr, input [7:0] wdata, output [7:0] rdata);
        reg [23:0] word;
        integer    i;
        begin
            word = {rd, addr, wdata};
            rdata = 8'h00;
            @(posedge clk_in);
            spi_cs_n_out <= 1'b0;
            for (i = 23; i >= 0; i = i - 1) begin
                spi_sdi_out <= word[i];
                repeat (5) @(posedge clk_in);
                spi_sclk_out <= 1'b1;
                if (i < 8)
                    rdata = {rdata[6:0], spi_sdo_in};
                repeat (5) @(posedge clk_in);
                spi_sclk_out <= 1'b0;
            end
            repeat (5) @(posedge clk_in);
            spi_cs_n_out <= 1'b1;
            // Released line must not keep its last bit
            spi_sdi_out <= ~spi_sdi_out;
            repeat (5) @(posedge clk_in);
        end
    endtask
endmodule // ascc_host

// ### testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
    // ==========
    // Signals
    reg         core_clk_in;
    reg         reset_n_in;
    reg         sync_in;
    reg         sleep_control_pin_in;
    wire        spi_sclk_in;
    wire        spi_cs_n_in;
    wire        spi_sdi_in;
    wire        spi_sdo_out;
    wire        spi_sdo_oe_n_out;
    wire [1:0]  sample_strobe_out;
    wire [1:0]  sample_clk_out;
    wire [7:0]  fine_delay_step_a_out;
    wire [7:0]  fine_delay_step_b_out;
    wire        datapath_reset_out;
    wire        ref_external_out;
    wire        power_down_out;
    wire        standby_out;
    wire        temp_diode_en_out;
    wire        fast_detect_out_a_temp_out;
    integer     bad_count;
    integer     n_tests;
    integer     dp_cnt;
    integer     i, c, k, p, h, d0, d4;
    reg  [7:0]  rv;
    reg  [11:0] rr [0:3];
    reg  [25:0] rows [0:8];
    ascc_top uut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
        .spi_sclk_in(spi_sclk_in), .spi_cs_n_in(spi_cs_n_in), .spi_sdi_in(spi_sdi_in),
        .spi_sdo_out(spi_sdo_out), .spi_sdo_oe_n_out(spi_sdo_oe_n_out), .sync_in(sync_in),
        .sleep_control_pin_in(sleep_control_pin_in), .sample_strobe_out(sample_strobe_out),
        .sample_clk_out(sample_clk_out), .fine_delay_step_a_out(fine_delay_step_a_out),
        .fine_delay_step_b_out(fine_delay_step_b_out),
        .datapath_reset_out(datapath_reset_out), .ref_external_out(ref_external_out),
        .power_down_out(power_down_out), .standby_out(standby_out),
        .temp_diode_en_out(temp_diode_en_out),
        .fast_detect_out_a_temp_out(fast_detect_out_a_temp_out));
    ascc_host host (.clk_in(core_clk_in), .spi_sdo_in(spi_sdo_out),
        .spi_sclk_out(spi_sclk_in), .spi_cs_n_out(spi_cs_n_in), .spi_sdi_out(spi_sdi_in));
    // ==========
    // Helpers
    always #12.5 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) if (datapath_reset_out === 1'b1) dp_cnt = dp_cnt + 1;
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task check_idle;
        check({datapath_reset_out, power_down_out, spi_sdo_oe_n_out, sample_strobe_out},
              5'h04);
    endtask
    task wr(input [14:0] a, input [7:0] d);
        host.xfer(1'b0, a, d, rv);
    endtask
    task rd(input [14:0] a);
        host.xfer(1'b1, a, 8'h00, rv);
    endtask
    task wait_s(input integer ch);
        begin
            k = 0;
            @(posedge core_clk_in);
            while (sample_strobe_out[ch] !== 1'b1 && k < 20) begin
                @(posedge core_clk_in);
                k = k + 1;
            end
        end
    endtask
    task sync_off(output integer d);
        begin
            @(posedge core_clk_in);
            sync_in <= 1'b1;
            repeat (12) @(posedge core_clk_in);
            wait_s(0);
            d = (13 + k) % 8;
            sync_in <= 1'b0;
        end
    endtask
    task report_and_stop;
        begin
            $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
            if (bad_count == 0 && n_tests > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // ==========
    // Watchdog, about three times the expected run
    initial begin
        #1000000;
        bad_count = bad_count + 1;
        report_and_stop;
    end
    // ==========
    // Main sequence
    initial begin
        core_clk_in = 1'b0;
        reset_n_in = 1'b0;
        sync_in = 1'b0;
        sleep_control_pin_in = 1'b0;
        bad_count = 0;
        n_tests = 0;
        dp_cnt = 0;
        rr[0] = 12'h011;
        rr[1] = 12'h121;
        rr[2] = 12'h242;
        rr[3] = 12'h384;
        rows[0] = {12'h024, 8'h01, 1'b0, 5'b10000};
        rows[1] = {12'h03F, 8'h02, 1'b0, 5'b10100};
        rows[2] = {12'h03F, 8'h03, 1'b0, 5'b11000};
        rows[3] = {12'h03F, 8'h00, 1'b0, 5'b10000};
        rows[4] = {12'h024, 8'h00, 1'b1, 5'b01000};
        rows[5] = {12'h040, 8'h40, 1'b1, 5'b00100};
        rows[6] = {12'h008, 8'h01, 1'b0, 5'b00000};
        rows[7] = {12'h028, 8'h01, 1'b0, 5'b00010};
        rows[8] = {12'h040, 8'h01, 1'b0, 5'b00011};
        repeat (5) @(posedge core_clk_in);
        check_idle;
        reset_n_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        rd(15'h008);
        check(rv, 8'h03);
        rd(15'h10B);
        check(rv, 8'h00);
        $display("reset test done");
        for (i = 0; i < 9; i = i + 1) begin
            sleep_control_pin_in <= rows[i][5];
            wr({3'h0, rows[i][25:14]}, rows[i][13:6]);
            rd({3'h0, rows[i][25:14]});
            check(rv, rows[i][13:6]);
            check({ref_external_out, power_down_out, standby_out, temp_diode_en_out,
                   fast_detect_out_a_temp_out}, rows[i][4:0]);
        end
        $display("register rows done");
        // Ratio is programmed before any period is measured
        for (i = 0; i < 4; i = i + 1) begin
            wr(15'h10B, {4'h0, rr[i][11:8]});
            wait_s(0);
            p = 0;
            h = 0;
            do begin
                @(posedge core_clk_in);
                p = p + 1;
                h = h + sample_clk_out[0];
            end while (sample_strobe_out[0] !== 1'b1 && p < 20);
            check(p, rr[i][7:4]);
            check(h, rr[i][3:0]);
        end
        $display("ratio test done");
        for (i = 0; i < 3; i = i + 1) begin
            wr(15'h10C, i[7:0]);
            wait_s(1);
            wait_s(0);
            check((1 + k) % 8, (i == 2) ? 7 : i);
        end
        wr(15'h10C, 8'h00);
        $display("half period test done");
        wr(15'h10D, 8'h80);
        sync_off(d0);
        wr(15'h10D, 8'h84);
        sync_off(d4);
        check((d0 + 8 - d4) % 8, 4);
        wr(15'h10D, 8'h80);
        sync_off(p);
        check(p, d0);
        $display("sync test done");
        dp_cnt = 0;
        wr(15'h117, 8'h01);
        repeat (10) @(posedge core_clk_in);
        check(dp_cnt, 4);
        // Codes 0, 59, 118, 177 and 236 reach both ends and the clamp
        for (c = 0; c < 256; c = c + 59) begin
            wr(15'h118, c[7:0]);
            repeat (10) @(posedge core_clk_in);
            check(fine_delay_step_a_out, (((c > 177) ? 177 : c) - 89) & 8'hFF);
        end
        check(fine_delay_step_b_out, 8'h00);
        wr(15'h008, 8'h02);
        wr(15'h118, 8'hB1);
        wr(15'h117, 8'h01);
        repeat (10) @(posedge core_clk_in);
        check(fine_delay_step_b_out, 8'h58);
        wr(15'h008, 8'h03);
        wr(15'h117, 8'h00);
        repeat (10) @(posedge core_clk_in);
        check({fine_delay_step_a_out, fine_delay_step_b_out}, 16'h0000);
        check(dp_cnt, 8);
        $display("fine delay test done");
        wr(15'h123, 8'h5A);
        rd(15'h123);
        check(rv, 8'h00);
        $display("unmapped test done");
        // Second reset in mid-run must return the index, diode and ratio registers to their reset values and clear the outputs
        reset_n_in <= 1'b0;
        repeat (5) @(posedge core_clk_in);
        check_idle;
        check({ref_external_out, power_down_out, standby_out, temp_diode_en_out,
               fast_detect_out_a_temp_out}, 5'h00);
        reset_n_in <= 1'b1;
        @(posedge core_clk_in);
        check_idle;
        repeat (2) @(posedge core_clk_in);
        rd(15'h008);
        check(rv, 8'h03);
        rd(15'h028);
        check(rv, 8'h00);
        rd(15'h10B);
        check(rv, 8'h00);
        $display("mid-run reset test done");
        report_and_stop;
    end
endmodule // testbench
